// File: clh_pkg.sv
package clh_pkg;
  localparam int unsigned CLH_BUSY_CYCLES  = 185;
  localparam logic [6:0]  CLH_ADDR_ZERO    = 7'h00;
  localparam logic [6:0]  CLH_ONE_LINE_TOP = 7'h4f;
  localparam logic [6:0]  CLH_L1_TOP       = 7'h27;
  localparam logic [6:0]  CLH_L2_BASE      = 7'h40;
  localparam logic [6:0]  CLH_L2_TOP       = 7'h67;
  localparam logic [4:0]  CLH_DUTY_8       = 5'h08;
  localparam logic [4:0]  CLH_DUTY_11      = 5'h0b;
  localparam logic [4:0]  CLH_DUTY_16      = 5'h10;
  localparam int unsigned CLH_BIT_WIDTH    = 4;
  localparam int unsigned CLH_BIT_LINES    = 3;
  localparam int unsigned CLH_BIT_FONT     = 2;
  localparam int unsigned CLH_BIT_ENTRY    = 1;
  localparam int unsigned CLH_BIT_BUSY     = 7;
  localparam logic [1:0]  CLH_STRAP_SAMPLE = 2'h2;
  localparam logic [1:0]  CLH_STRAP_DONE   = 2'h3;

  typedef struct packed {
    logic       rs;
    logic [7:0] data;
  } clh_word_s;

  typedef struct packed {
    logic       wide;
    logic       two_line;
    logic       big_font;
    logic       inc;
  } clh_cfg_s;
endpackage

// File: clh_fifo.sv
`timescale 1ns/1ns
`default_nettype none
module clh_fifo
  import clh_pkg::*;
#(
  parameter int unsigned WIDTH = 9,
  parameter int unsigned DEPTH = 4
)
(
  input  wire logic             clk,
  input  wire logic             rst,
  input  wire logic             ce,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);
  localparam int unsigned AW = $clog2(DEPTH);
  initial if (DEPTH < 2 || (1 << AW) != DEPTH) $error("DEPTH must be a power of two >= 2");
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0]      wp_reg;
  logic [AW:0]      rp_reg;
  wire logic        push = ce && in_valid && in_ready;
  wire logic        pop  = ce && out_valid && out_ready;
  assign in_ready  = (wp_reg - rp_reg) != (AW+1)'(DEPTH);
  assign out_valid = wp_reg != rp_reg;
  assign out_data  = mem[rp_reg[AW-1:0]];
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      wp_reg <= '0;
      rp_reg <= '0;
    end
    else
    begin
      if (push)
        wp_reg <= wp_reg + 1'b1;
      if (pop)
        rp_reg <= rp_reg + 1'b1;
    end
  end
  always_ff @(posedge clk)
  begin
    if (push)
      mem[wp_reg[AW-1:0]] <= in_data;
  end
endmodule
`default_nettype wire

// File: clh_top.sv
`timescale 1ns/1ns
`default_nettype none
module clh_top
  import clh_pkg::*;
#(
  parameter int unsigned BUSY_CYCLES = CLH_BUSY_CYCLES
)
(
  // Clock, reset, enable
  input  wire logic       REF_CLK_IN,
  input  wire logic       RST_IN,
  input  wire logic       CE_IN,
  // Straps
  input  wire logic       HOST_SEL_STRAP_HI_IN,
  input  wire logic       HOST_SEL_STRAP_LO_IN,
  // Parallel bus
  input  wire logic       STROBE_IN,
  input  wire logic       REG_SELECT_IN,
  input  wire logic       READ_NOT_WRITE_IN,
  input  wire logic [7:0] DB_IN,
  output logic      [7:0] DB_OUT,
  output logic      [7:0] DB_OE_OUT,
  // Status
  output logic            INTERNAL_OP_FLAG_OUT,
  output logic      [6:0] ADDR_COUNTER_OUT,
  output logic            TWO_LINE_OUT,
  output logic            BIG_FONT_OUT,
  output logic      [4:0] DUTY_OUT,
  output logic            SERIAL_MODE_OUT,
  output logic            TWO_WIRE_SEL_OUT
);
  initial if (BUSY_CYCLES < 1 || BUSY_CYCLES > 255) $error("BUSY_CYCLES out of range");

  // Two-flop sync of the bus and strap pins; stage one is only read by stage two.
  logic [12:0] s1_reg;
  logic [12:0] s2_reg;
  always_ff @(posedge REF_CLK_IN or posedge RST_IN)
  begin
    if (RST_IN)
    begin
      s1_reg <= '0;
      s2_reg <= '0;
    end
    else if (CE_IN)
    begin
      s1_reg <= {STROBE_IN, REG_SELECT_IN, READ_NOT_WRITE_IN, DB_IN, HOST_SEL_STRAP_HI_IN,
                 HOST_SEL_STRAP_LO_IN};
      s2_reg <= s1_reg;
    end
  end
  wire logic       e_s   = s2_reg[12];
  wire logic       rs_s  = s2_reg[11];
  wire logic       rw_s  = s2_reg[10];
  wire logic [7:0] db_s  = s2_reg[9:2];
  wire logic       shi_s = s2_reg[1];
  wire logic       slo_s = s2_reg[0];

  typedef struct packed {
    logic       ser;
    logic       e_d;
    logic       sck_d;
    logic       nib_lo;
    logic [3:0] nib_hi;
    logic [2:0] bitcnt;
    logic [7:0] shreg;
    clh_cfg_s   cfg;
    logic       glyph;
    logic [6:0] ac;
    logic [7:0] busy_cnt;
    logic [7:0] out_reg;
    logic [7:0] db_o;
    logic       drive;
  } clh_state_s;
  clh_state_s st_reg;
  clh_state_s st_next;

  logic [7:0] text_mem  [128];
  logic [7:0] glyph_mem [64];

  // Word path through the FIFO; a word that arrives while the FIFO is full is dropped.
  clh_word_s  w_in;
  clh_word_s  w_out;
  logic       w_in_valid;
  logic       w_in_ready;
  logic       w_out_valid;
  logic       w_out_ready;
  clh_fifo #(.WIDTH(9), .DEPTH(4)) u_fifo (
    .clk       (REF_CLK_IN),
    .rst       (RST_IN),
    .ce        (CE_IN),
    .in_valid  (w_in_valid),
    .in_ready  (w_in_ready),
    .in_data   (w_in),
    .out_valid (w_out_valid),
    .out_ready (w_out_ready),
    .out_data  (w_out)
  );

  function automatic logic [6:0] step_addr(input logic [6:0] a, input logic inc,
                                           input logic glyph, input logic two);
    logic [6:0] r;
    r = inc ? 7'(a + 7'h01) : 7'(a - 7'h01);
    if (glyph)
      r[6] = 1'b0;
    else if (!two)
    begin
      if (inc && a == CLH_ONE_LINE_TOP) r = CLH_ADDR_ZERO;
      if (!inc && a == CLH_ADDR_ZERO)   r = CLH_ONE_LINE_TOP;
    end
    else
    begin
      if (inc && a == CLH_L1_TOP)        r = CLH_L2_BASE;
      if (inc && a == CLH_L2_TOP)        r = CLH_ADDR_ZERO;
      if (!inc && a == CLH_L2_BASE)      r = CLH_L1_TOP;
      if (!inc && a == CLH_ADDR_ZERO)    r = CLH_L2_TOP;
    end
    return r;
  endfunction

  wire logic serial   = st_reg.ser;
  wire logic e_fall   = st_reg.e_d && !e_s;
  wire logic sck_rise = !st_reg.sck_d && db_s[6];
  wire logic busy     = st_reg.busy_cnt != 8'h00;
  wire logic [7:0] rd_addr_word = {busy, st_reg.ac};

  always_comb
  begin
    st_next     = st_reg;
    w_in        = '0;
    w_in_valid  = 1'b0;
    w_out_ready = !busy;
    st_next.e_d   = e_s;
    st_next.sck_d = db_s[6];
    if (busy)
      st_next.busy_cnt = 8'(st_reg.busy_cnt - 8'h01);
    if (!serial)
    begin
      if (e_fall && !rw_s && w_in_ready)
      begin
        if (st_reg.cfg.wide)
        begin
          w_in_valid = 1'b1;
          w_in       = '{rs: rs_s, data: db_s};
        end
        else if (!st_reg.nib_lo)
        begin
          st_next.nib_hi = db_s[7:4];
          st_next.nib_lo = 1'b1;
        end
        else
        begin
          w_in_valid     = 1'b1;
          w_in           = '{rs: rs_s, data: {st_reg.nib_hi, db_s[7:4]}};
          st_next.nib_lo = 1'b0;
        end
      end
      if (e_fall && rw_s)
      begin
        if (!st_reg.cfg.wide)
          st_next.nib_lo = !st_reg.nib_lo;
        if (rs_s && (st_reg.cfg.wide || st_reg.nib_lo))
        begin
          st_next.ac = step_addr(st_reg.ac, st_reg.cfg.inc, st_reg.glyph,
                                 st_reg.cfg.two_line);
          st_next.out_reg = st_reg.glyph ? glyph_mem[st_next.ac[5:0]] : text_mem[st_next.ac];
        end
      end
      st_next.drive = rw_s && e_s;
      if (rs_s)
        st_next.db_o = (st_reg.cfg.wide || !st_reg.nib_lo) ? st_reg.out_reg
                       : {st_reg.out_reg[3:0], 4'h0};
      else
        st_next.db_o = (st_reg.cfg.wide || !st_reg.nib_lo) ? rd_addr_word
                       : {rd_addr_word[3:0], 4'h0};
    end
    else
    begin
      st_next.drive = 1'b0;
      if (db_s[5])
        st_next.bitcnt = 3'h0;
      else if (sck_rise)
      begin
        st_next.shreg  = {st_reg.shreg[6:0], db_s[7]};
        st_next.bitcnt = 3'(st_reg.bitcnt + 3'h1);
        if (st_reg.bitcnt == 3'h7 && w_in_ready)
        begin
          w_in_valid = 1'b1;
          w_in       = '{rs: rs_s, data: {st_reg.shreg[6:0], db_s[7]}};
        end
      end
    end
    if (w_out_valid && !busy)
    begin
      st_next.busy_cnt = 8'(BUSY_CYCLES);
      if (w_out.rs)
      begin
        st_next.ac = step_addr(st_reg.ac, st_reg.cfg.inc, st_reg.glyph,
                               st_reg.cfg.two_line);
      end
      else if (w_out.data[7])
      begin
        st_next.ac      = w_out.data[6:0];
        st_next.glyph   = 1'b0;
        st_next.out_reg = text_mem[w_out.data[6:0]];
      end
      else if (w_out.data[6])
      begin
        st_next.ac      = {1'b0, w_out.data[5:0]};
        st_next.glyph   = 1'b1;
        st_next.out_reg = glyph_mem[w_out.data[5:0]];
      end
      else if (w_out.data[5])
      begin
        st_next.cfg.wide     = w_out.data[CLH_BIT_WIDTH] || serial;
        st_next.cfg.two_line = w_out.data[CLH_BIT_LINES];
        st_next.cfg.big_font = w_out.data[CLH_BIT_FONT];
        st_next.nib_lo       = 1'b0;
      end
      else if (w_out.data[4] && !w_out.data[3])
      begin
        st_next.ac = step_addr(st_reg.ac, w_out.data[2], st_reg.glyph, st_reg.cfg.two_line);
        if (!st_reg.glyph)
          st_next.out_reg = text_mem[st_next.ac];
      end
      else if (w_out.data[2] && !w_out.data[4] && !w_out.data[3])
        st_next.cfg.inc = w_out.data[CLH_BIT_ENTRY];
      else if (w_out.data[1] && w_out.data[7:2] == 6'h00)
        st_next.ac = CLH_ADDR_ZERO;
    end
  end

  always_ff @(posedge REF_CLK_IN)
  begin
    if (CE_IN && w_out_valid && !busy && w_out.rs)
    begin
      if (st_reg.glyph)
        glyph_mem[st_reg.ac[5:0]] <= w_out.data;
      else
        text_mem[st_reg.ac] <= w_out.data;
    end
  end

  // The serial-mode strap is taken only once both synchroniser stages hold pin values, not reset zeros.
  logic [1:0] strap_wait_reg;
  always_ff @(posedge REF_CLK_IN or posedge RST_IN)
  begin
    if (RST_IN)
    begin
      st_reg          <= '0;
      st_reg.cfg.wide <= 1'b1;
      st_reg.cfg.inc  <= 1'b1;
      strap_wait_reg  <= 2'h0;
    end
    else if (CE_IN)
    begin
      st_reg <= st_next;
      if (strap_wait_reg != CLH_STRAP_DONE)
        strap_wait_reg <= 2'(strap_wait_reg + 2'h1);
      if (strap_wait_reg == CLH_STRAP_SAMPLE)
        st_reg.ser <= shi_s && !slo_s;
    end
  end

  assign DB_OUT               = st_reg.db_o;
  assign DB_OE_OUT            = {8{st_reg.drive}};
  assign INTERNAL_OP_FLAG_OUT = busy;
  assign ADDR_COUNTER_OUT     = st_reg.ac;
  assign TWO_LINE_OUT         = st_reg.cfg.two_line;
  assign BIG_FONT_OUT         = st_reg.cfg.big_font && !st_reg.cfg.two_line;
  assign DUTY_OUT             = st_reg.cfg.two_line ? CLH_DUTY_16
                              : (st_reg.cfg.big_font ? CLH_DUTY_11 : CLH_DUTY_8);
  assign SERIAL_MODE_OUT      = st_reg.ser;
  assign TWO_WIRE_SEL_OUT     = slo_s && !shi_s;

  chk_duty_two_line: assert property (@(posedge REF_CLK_IN) disable iff (RST_IN)
    TWO_LINE_OUT |-> DUTY_OUT == CLH_DUTY_16 && !BIG_FONT_OUT)
    else $error("two-line duty wrong");
  chk_busy_after_take: assert property (@(posedge REF_CLK_IN) disable iff (RST_IN)
    CE_IN && w_out_valid && !busy |=> INTERNAL_OP_FLAG_OUT)
    else $error("busy not raised");
  chk_text_range_one: assert property (@(posedge REF_CLK_IN) disable iff (RST_IN)
    !st_reg.glyph && !st_reg.cfg.two_line && st_reg.ac <= CLH_ONE_LINE_TOP
      |=> st_reg.ac <= CLH_ONE_LINE_TOP || $changed(st_reg.glyph) || w_out.data[7])
    else $error("text address out of range");
  chk_glyph_addr_six: assert property (@(posedge REF_CLK_IN) disable iff (RST_IN)
    st_reg.glyph |-> !st_reg.ac[6])
    else $error("glyph address too wide");
  chk_busy_read_bit: assert property (@(posedge REF_CLK_IN) disable iff (RST_IN)
    CE_IN && !serial && !rs_s && st_reg.cfg.wide |=> st_reg.db_o[CLH_BIT_BUSY] == $past(busy))
    else $error("busy bit not on DB7");
  chk_write_steps_ac: assert property (@(posedge REF_CLK_IN) disable iff (RST_IN)
    CE_IN && w_out_valid && !busy && w_out.rs && st_reg.cfg.inc && st_reg.glyph
      |=> st_reg.ac[5:0] == 6'($past(st_reg.ac[5:0]) + 6'h01))
    else $error("counter did not step");
  chk_serial_no_drive: assert property (@(posedge REF_CLK_IN) disable iff (RST_IN)
    serial |-> DB_OE_OUT == 8'h00)
    else $error("bus driven in serial mode");
  chk_busy_len: assert property (@(posedge REF_CLK_IN) disable iff (RST_IN)
    CE_IN && w_out_valid && !busy |=> st_reg.busy_cnt == 8'(BUSY_CYCLES))
    else $error("busy length wrong");
endmodule
`default_nettype wire

// File: clh_host_model.sv
`timescale 1ns/1ns
`default_nettype none
module clh_host_model
  import clh_pkg::*;
(
  // Clock and bus width
  input  wire logic       clk_in,
  input  wire logic       wide_in,
  // Lines to and from the block
  input  wire logic [7:0] db_in,
  output logic            strobe_out,
  output logic            rs_out,
  output logic            rw_out,
  output logic      [7:0] db_out
);
  initial
  begin
    strobe_out = 1'b0;
    rs_out     = 1'b0;
    rw_out     = 1'b0;
    db_out     = 8'hff;
  end

  // A read releases the bus, so the lines show the inverse of the last value.
  task automatic pulse(input logic rs, input logic rw, input logic [7:0] d,
                       output logic [7:0] q);
    @(posedge clk_in);
    rs_out <= rs;
    rw_out <= rw;
    db_out <= rw ? ~db_out : d;
    repeat (2) @(posedge clk_in);
    strobe_out <= 1'b1;
    repeat (6) @(posedge clk_in);
    q = db_in;
    strobe_out <= 1'b0;
    repeat (4) @(posedge clk_in);
  endtask

  task automatic xfer(input logic rs, input logic rw, input logic [7:0] d,
                      output logic [7:0] q);
    logic [7:0] hi;
    if (wide_in)
      pulse(rs, rw, d, q);
    else
    begin
      pulse(rs, rw, {d[7:4], 4'ha}, hi);
      pulse(rs, rw, {d[3:0], 4'h5}, q);
      q = {hi[7:4], q[7:4]};
    end
  endtask

  // The extra gap after busy drops covers four clock cycles.
  task automatic poll(output logic [7:0] q);
    q = 8'hff;
    for (int i = 0; i < 40 && q[7] !== 1'b0; i++)
      xfer(1'b0, 1'b1, 8'h00, q);
    repeat (4) @(posedge clk_in);
  endtask

  task automatic cmd(input logic rs, input logic [7:0] d);
    logic [7:0] q;
    xfer(rs, 1'b0, d, q);
    poll(q);
  endtask

  task automatic idle();
    @(posedge clk_in);
    db_out <= 8'hff;
  endtask

  // Clock idles high; each bit is set up while the clock is low.
  task automatic ser_byte(input logic rs, input logic [7:0] d);
    @(posedge clk_in);
    rs_out    <= rs;
    db_out[5] <= 1'b0;
    for (int i = 7; i >= 0; i--)
    begin
      repeat (4) @(posedge clk_in);
      db_out[6] <= 1'b0;
      db_out[7] <= d[i];
      repeat (4) @(posedge clk_in);
      db_out[6] <= 1'b1;
    end
    repeat (4) @(posedge clk_in);
    db_out[5] <= 1'b1;
    db_out[7] <= ~d[0];
    repeat (20) @(posedge clk_in);
  endtask
endmodule
`default_nettype wire

// File: test_clh_top.sv
`timescale 1ns/1ns
`default_nettype none
module test_clh_top
  import clh_pkg::*;
;
  logic       clk = 1'b0;
  logic       rst = 1'b1;
  logic       strap_hi = 1'b0;
  logic       strap_lo = 1'b0;
  logic       wide = 1'b1;
  logic       ce = 1'b1;
  logic       strobe, rs, rw, busy, two_line, big_font, serial, two_wire;
  logic [7:0] db, db_out, db_oe, q;
  logic [6:0] ac;
  logic [4:0] duty;
  int         n_mismatch = 0;
  int         n_tests = 0;
  int         n_drive = 0;
  int         seed;

  clh_top #(.BUSY_CYCLES(4)) i_dut (.REF_CLK_IN(clk), .RST_IN(rst), .CE_IN(ce),
    .HOST_SEL_STRAP_HI_IN(strap_hi), .HOST_SEL_STRAP_LO_IN(strap_lo),
    .STROBE_IN(strobe), .REG_SELECT_IN(rs), .READ_NOT_WRITE_IN(rw), .DB_IN(db),
    .DB_OUT(db_out), .DB_OE_OUT(db_oe), .INTERNAL_OP_FLAG_OUT(busy),
    .ADDR_COUNTER_OUT(ac), .TWO_LINE_OUT(two_line), .BIG_FONT_OUT(big_font),
    .DUTY_OUT(duty), .SERIAL_MODE_OUT(serial), .TWO_WIRE_SEL_OUT(two_wire));

  clh_host_model i_host (.clk_in(clk), .wide_in(wide), .db_in(db_out),
    .strobe_out(strobe), .rs_out(rs), .rw_out(rw), .db_out(db));

  // Counts cycles in which the block drives the bus back to the host.
  always @(posedge clk)
  begin
    if (db_oe == 8'hff)
      n_drive <= n_drive + 1;
  end

  initial
  begin
    forever #50 clk = ~clk;
  end

  function automatic logic [4:0] duty_of(input logic n, input logic f);
    return n ? 5'h10 : (f ? 5'h0b : 5'h08);
  endfunction

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("[FAIL] t=%0t seen=%h expected=%h", $time, seen, exp);
    end
  endtask

  task automatic stop_test();
    $display("Comparisons %0d, mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  task automatic do_reset(input logic hi, input logic lo);
    @(posedge clk);
    rst      <= 1'b1;
    strap_hi <= hi;
    strap_lo <= lo;
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    repeat (8) @(posedge clk);
  endtask

  task automatic wr_rd(input logic [6:0] a, input logic [7:0] d, input logic [6:0] step);
    i_host.cmd(1'b0, {1'b1, a});
    i_host.cmd(1'b1, d);
    i_host.poll(q);
    chk(q, {1'b0, a + step});
    i_host.cmd(1'b0, {1'b1, a});
    i_host.xfer(1'b1, 1'b1, 8'h00, q);
    chk(q, d);
    i_host.poll(q);
    chk(q, {1'b0, a + step});
  endtask

  initial
  begin
    seed = $urandom(44);
    do_reset(1'b0, 1'b0);
    chk({busy, ac}, 8'h00);
    chk({3'h0, duty}, 8'h08);
    chk({6'h00, serial, two_wire}, 8'h00);
    for (int i = 0; i < 4; i++)
    begin
      i_host.cmd(1'b0, {4'h3, i[1:0], 2'b00});
      chk({6'h00, two_line, big_font}, {6'h00, i[1], i[1:0] == 2'b01});
      chk({3'h0, duty}, {3'h0, duty_of(i[1], i[0])});
    end
    i_host.cmd(1'b0, 8'h38);
    i_host.cmd(1'b0, 8'h04);
    wr_rd(7'h67, 8'h5a, 7'h7f);
    chk({7'h00, n_drive > 0}, 8'h01);
    chk(db_oe, 8'h00);
    wr_rd(7'h27, 8'hc3, 7'h7f);
    i_host.cmd(1'b0, 8'hc0);
    i_host.cmd(1'b1, 8'h11);
    i_host.poll(q);
    chk(q, 8'h27);
    i_host.cmd(1'b0, 8'h30);
    wr_rd(7'h4f, 8'h3c, 7'h7f);
    i_host.cmd(1'b0, 8'h14);
    i_host.xfer(1'b1, 1'b1, 8'h00, q);
    chk(q, 8'h3c);
    i_host.cmd(1'b0, 8'h06);
    i_host.cmd(1'b0, 8'hcf);
    i_host.cmd(1'b1, 8'h22);
    i_host.poll(q);
    chk(q, 8'h00);
    repeat (8) wr_rd(7'($urandom_range(77)), 8'($urandom), 7'h01);
    i_host.cmd(1'b0, 8'h55);
    i_host.cmd(1'b1, 8'h9e);
    i_host.poll(q);
    chk(q, 8'h16);
    i_host.cmd(1'b0, 8'h55);
    i_host.xfer(1'b1, 1'b1, 8'h00, q);
    chk(q, 8'h9e);
    // The busy poll after the width change already moves in nibbles.
    i_host.xfer(1'b0, 1'b0, 8'h20, q);
    wide = 1'b0;
    i_host.poll(q);
    chk(q, 8'h16);
    i_host.pulse(1'b0, 1'b0, 8'h8a, q);
    repeat (2) @(posedge clk);
    chk({7'h00, busy}, 8'h00);
    i_host.pulse(1'b0, 1'b0, 8'h3a, q);
    i_host.poll(q);
    chk(q, 8'h03);
    wr_rd(7'h2b, 8'h7e, 7'h01);
    i_host.cmd(1'b0, 8'h30);
    wide = 1'b1;
    wr_rd(7'h11, 8'he1, 7'h01);
    ce <= 1'b0;
    i_host.pulse(1'b0, 1'b0, 8'hc0, q);
    ce <= 1'b1;
    repeat (8) @(posedge clk);
    chk({1'b0, ac}, 8'h12);
    i_host.idle();
    do_reset(1'b1, 1'b0);
    chk({6'h00, serial, two_wire}, 8'h02);
    i_host.ser_byte(1'b0, 8'hb1);
    i_host.ser_byte(1'b1, 8'h44);
    chk({1'b0, ac}, 8'h32);
    i_host.ser_byte(1'b0, 8'h38);
    chk({7'h00, two_line}, 8'h01);
    do_reset(1'b0, 1'b1);
    chk({7'h00, two_wire}, 8'h01);
    do_reset(1'b1, 1'b1);
    chk({7'h00, serial}, 8'h00);
    wr_rd(7'h05, 8'h69, 7'h01);
    stop_test();
  end

  initial
  begin
    repeat (30000) @(posedge clk);
    n_mismatch++;
    stop_test();
  end
endmodule
`default_nettype wire
